// *** src/scfg_pkg.sv ***
/*
  shared constants of the synthesizer configuration link: word layout,
  control codes, forced defaults and the host's register map.
  assumes 24-bit words, register data in bits 23:4, code in bits 3:0.
*/
package scfg_pkg;

  localparam int unsigned WORD_W      = 24;
  localparam int unsigned DATA_W      = 20;
  localparam int unsigned CODE_W      = 4;
  localparam int unsigned CODE_LSB    = 0;
  localparam int unsigned DATA_LSB    = 4;

  ////////////////////////////////////////////////////////////////////////
  // control codes; the main frequency word only needs bit 0 clear
  localparam logic [3:0] CODE_AUX_N      = 4'h5;
  localparam logic [3:0] CODE_REF_ACCESS = 4'h7;
  localparam logic [3:0] CODE_FASTLOCK   = 4'h9;
  localparam logic [3:0] CODE_EXT_FRAC   = 4'hB;
  localparam logic [3:0] CODE_TIMEOUT    = 4'hD;
  localparam logic [3:0] CODE_CNT_RESET  = 4'hF;
  localparam int unsigned MAIN_CODE_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////
  // field positions inside the 24-bit word
  localparam int unsigned AUX_PD_BIT     = 23;
  localparam int unsigned AUX_N_MSB      = 22;
  localparam int unsigned AUX_N_LSB      = 4;
  localparam int unsigned AUTO_POWER_UP_BIT       = 23;
  localparam int unsigned AUX_PRE_BIT    = 8;
  localparam int unsigned ACCESS_MSB     = 23;
  localparam int unsigned ACCESS_LSB     = 20;
  localparam int unsigned GAIN_MSB       = 19;
  localparam int unsigned GAIN_LSB       = 16;
  localparam int unsigned REF_MSB        = 15;
  localparam int unsigned REF_LSB        = 4;
  localparam int unsigned ACC_FIXED_BIT  = 20;

  ////////////////////////////////////////////////////////////////////////
  // forced defaults of the optional words (data field only) and host legality minimums
  localparam logic [19:0] EXT_FRAC_DFLT  = 20'h00000;
  localparam logic [19:0] TIMEOUT_DFLT   = 20'h00000;
  localparam logic [19:0] CNT_RESET_DFLT = 20'h00090;
  localparam logic [11:0] AUX_REF_MIN    = 12'h003;
  localparam logic [18:0] AUX_N_WIDE_MIN = 19'h000F0;
  localparam logic [14:0] AUX_B_MIN      = 15'h0003;

  ////////////////////////////////////////////////////////////////////////
  // host timing, in cycles of clk_i
  localparam int unsigned LINK_HALF      = 2;
  localparam int unsigned LATCH_HOLD     = 8;

  ////////////////////////////////////////////////////////////////////////
  // host apb map
  localparam logic [7:0] OFS_TX_WORD     = 8'h00;
  localparam logic [7:0] OFS_CTRL        = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic       CE_RESET        = 1'b0;

endpackage

// *** src/scfg_if.sv ***
/*
  three-wire write link plus chip enable between host and synthesizer.
  assumes the host drives every wire; the device only listens.
*/
interface scfg_if;
  logic link_clk;
  logic sdata;
  logic latch;
  logic chip_en;

  modport host
  (
    output link_clk,
    output sdata,
    output latch,
    output chip_en
  );

  modport device
  (
    input link_clk,
    input sdata,
    input latch,
    input chip_en
  );
endinterface

// *** src/scfg_device.sv ***
/*
  synthesizer end of the configuration link: shift register on the link
  clock, word latch and configuration registers on clk_i.
  assumes the link clock stands still while latch is high and the word
  is held stable until the latch has been seen by clk_i.
*/
// Behaviour
// R1: word is 20 data bits plus code
// R2: host avoids illegal wide-prescaler aux divides
// R3: aux power-down bit stops aux loop, tristates pump
// R4: main word write with auto-power-up clears bit
// R5: chip enable low forces aux power down
// R6: aux reference divider from bits 15:4
// R7: pump gain code n gives n+1 times
// R8: host always writes base registers zero to four
// R9: access bit 20 fixed one, 21-23 select
// R10: defaulted optional registers forced to defaults
// R11: host writes each programmable optional register
// R12: defaults zero, zero, and bits 11,8 set
// R13: effective power-down is enable low or bit
module scfg_device
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  scfg_if.device            link,
  output logic              aux_power_down_o,
  output logic              aux_pump_tristate_o,
  output logic [18:0]       aux_n_o,
  output logic              aux_prescaler_wide_o,
  output logic [11:0]       aux_ref_div_o,
  output logic [3:0]        main_pump_gain_o,
  output logic [4:0]        main_pump_mult_o,
  output logic [3:0]        access_o,
  output logic              auto_power_up_o,
  output logic [19:0]       main_frequency_o,
  output logic              main_freq_wr_o,
  output logic [19:0]       ext_fraction_o,
  output logic [19:0]       fastlock_timeout_o,
  output logic [19:0]       counter_reset_o,
  output logic              access_fault_o
);
  import scfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // link domain: shift only while latch is low
  logic [23:0] shift_reg;

  // R1 word assembly
  always_ff @(posedge link.link_clk)
  begin
    if (!link.latch)
    begin
      shift_reg <= {shift_reg[22:0], link.sdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing: latch level synchronised; shift_reg is frozen while it is
  // high, so it is sampled only after the synchronised rising edge
  logic latch_s1_reg;
  logic latch_s2_reg;
  logic latch_s3_reg;
  logic ce_s1_reg;
  logic ce_s2_reg;
  logic word_take;
  logic [23:0] word;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      latch_s1_reg <= 1'b1;
      latch_s2_reg <= 1'b1;
      latch_s3_reg <= 1'b1;
      ce_s1_reg    <= 1'b0;
      ce_s2_reg    <= 1'b0;
    end
    else
    begin
      latch_s1_reg <= link.latch;
      latch_s2_reg <= latch_s1_reg;
      latch_s3_reg <= latch_s2_reg;
      ce_s1_reg    <= link.chip_en;
      ce_s2_reg    <= ce_s1_reg;
    end
  end

  assign word_take = latch_s2_reg & ~latch_s3_reg;
  assign word      = shift_reg;

  function automatic logic code_is(input logic [23:0] w, input logic [3:0] c);
    return w[CODE_W-1:CODE_LSB] == c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // stored words
  logic        aux_pd_reg;
  logic [19:0] ref_word_reg;
  logic [19:0] ext_frac_reg;
  logic [19:0] timeout_reg;
  logic [19:0] cnt_reset_reg;
  logic        main_wr;

  assign main_wr = word_take & ~word[MAIN_CODE_BIT];

  // R3 stored power-down bit
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aux_pd_reg <= 1'b1;
    end
    // R4 auto power-up clears the stored bit
    // R13 clear acts on the qualifying write
    else if (main_wr && auto_power_up_o)
    begin
      aux_pd_reg <= 1'b0;
    end
    else if (word_take && code_is(word, CODE_AUX_N))
    begin
      aux_pd_reg <= word[AUX_PD_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aux_n_o <= '0;
    end
    else if (word_take && code_is(word, CODE_AUX_N))
    begin
      aux_n_o <= word[AUX_N_MSB:AUX_N_LSB];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      auto_power_up_o      <= 1'b0;
      aux_prescaler_wide_o <= 1'b0;
    end
    else if (word_take && code_is(word, CODE_FASTLOCK))
    begin
      auto_power_up_o      <= word[AUTO_POWER_UP_BIT];
      aux_prescaler_wide_o <= word[AUX_PRE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ref_word_reg <= '0;
    end
    else if (word_take && code_is(word, CODE_REF_ACCESS))
    begin
      ref_word_reg <= word[23:DATA_LSB];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      main_frequency_o <= '0;
      main_freq_wr_o   <= 1'b0;
    end
    else
    begin
      main_freq_wr_o <= main_wr;
      if (main_wr)
      begin
        main_frequency_o <= word[23:DATA_LSB];
      end
    end
  end

  // optional words are stored whatever the access bits say, so turning
  // an access bit on later exposes the last written value
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ext_frac_reg  <= EXT_FRAC_DFLT;
      timeout_reg   <= TIMEOUT_DFLT;
      cnt_reset_reg <= CNT_RESET_DFLT;
    end
    else if (word_take)
    begin
      if (code_is(word, CODE_EXT_FRAC))
      begin
        ext_frac_reg <= word[23:DATA_LSB];
      end
      if (code_is(word, CODE_TIMEOUT))
      begin
        timeout_reg <= word[23:DATA_LSB];
      end
      if (code_is(word, CODE_CNT_RESET))
      begin
        cnt_reset_reg <= word[23:DATA_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output stage, all registered
  logic [3:0] acc;
  assign acc = ref_word_reg[ACCESS_MSB-DATA_LSB:ACCESS_LSB-DATA_LSB];

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aux_power_down_o    <= 1'b1;
      aux_pump_tristate_o <= 1'b1;
    end
    else
    begin
      // R5 chip enable low overrides
      // R13 effective power-down
      aux_power_down_o    <= ~ce_s2_reg | aux_pd_reg;
      // R3 pump tristated with the loop
      aux_pump_tristate_o <= ~ce_s2_reg | aux_pd_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aux_ref_div_o    <= '0;
      main_pump_gain_o <= '0;
      main_pump_mult_o <= '0;
      access_o         <= '0;
      access_fault_o   <= 1'b0;
    end
    else
    begin
      // R6 reference divider field
      aux_ref_div_o    <= ref_word_reg[REF_MSB-DATA_LSB:REF_LSB-DATA_LSB];
      main_pump_gain_o <= ref_word_reg[GAIN_MSB-DATA_LSB:GAIN_LSB-DATA_LSB];
      // R7 gain multiple n+1
      main_pump_mult_o <= 5'(ref_word_reg[GAIN_MSB-DATA_LSB:GAIN_LSB-DATA_LSB]) + 5'h01;
      access_o         <= acc;
      // R9 fixed access bit must read one
      access_fault_o   <= ~acc[ACC_FIXED_BIT-ACCESS_LSB];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ext_fraction_o     <= EXT_FRAC_DFLT;
      fastlock_timeout_o <= TIMEOUT_DFLT;
      counter_reset_o    <= CNT_RESET_DFLT;
    end
    else
    begin
      // R9 access bits select programmed words
      // R10 defaulted words forced
      // R12 default values
      ext_fraction_o     <= acc[1] ? ext_frac_reg : EXT_FRAC_DFLT;
      fastlock_timeout_o <= acc[2] ? timeout_reg : TIMEOUT_DFLT;
      counter_reset_o    <= acc[3] ? cnt_reset_reg : CNT_RESET_DFLT;
    end
  end

endmodule

// *** src/scfg_host.sv ***
/*
  host end: apb slave taking 24-bit words from software and sending them
  over the three-wire link, with its own divided link clock.
  assumes an apb master on clk_i that tolerates one wait state.
*/
module scfg_host
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [7:0]   paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  scfg_if.host              link
);
  import scfg_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LATCH} scfg_state_t;

  scfg_state_t state_reg;
  logic [23:0] tx_reg;
  logic [23:0] last_reg;
  logic [4:0]  bit_reg;
  logic [3:0]  cnt_reg;
  logic        ce_reg;
  logic        wide_reg;
  logic        reject_reg;
  logic [4:0]  base_reg;
  logic        wr_acc;
  logic        rd_acc;
  logic        take;
  logic        legal;
  logic [23:0] wword;

  function automatic logic aux_n_legal(input logic [18:0] n, input logic wide);
    return !wide || (n >= AUX_N_WIDE_MIN) ||
           ((n[18:4] >= AUX_B_MIN) && (n[3:0] <= n[7:4]));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb: one wait state, answer on the second access cycle
  assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pready_o & ~pwrite_i;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end
    else
    begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & (paddr_i != OFS_TX_WORD) &
                   (paddr_i != OFS_CTRL) & (paddr_i != OFS_STATUS);
      prdata_o  <= '0;
      if (rd_acc)
      begin
        case (paddr_i)
          OFS_TX_WORD: prdata_o <= {8'h00, last_reg};
          OFS_CTRL:    prdata_o <= {31'h00000000, ce_reg};
          OFS_STATUS:  prdata_o <= {24'h000000, base_reg, &base_reg, reject_reg,
                                    state_reg != ST_IDLE};
          default:     prdata_o <= '0;
        endcase
      end
    end
  end

  // R9 fixed access bit always sent as one
  assign wword = (pwdata_i[3:0] == CODE_REF_ACCESS) ?
                 (pwdata_i[23:0] | (24'h000001 << ACC_FIXED_BIT)) : pwdata_i[23:0];
  // R2 aux divide check under wide prescaler
  // R6 reference divider minimum
  assign legal = (wword[3:0] == CODE_AUX_N) ?
                   aux_n_legal(wword[AUX_N_MSB:AUX_N_LSB], wide_reg) :
                 (wword[3:0] == CODE_REF_ACCESS) ?
                   (wword[REF_MSB:REF_LSB] >= AUX_REF_MIN) : 1'b1;
  assign take  = wr_acc & (paddr_i == OFS_TX_WORD) & (state_reg == ST_IDLE) & legal;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ce_reg <= CE_RESET;
    end
    else if (wr_acc && paddr_i == OFS_CTRL)
    begin
      ce_reg <= pwdata_i[0];
    end
  end

  // refused words raise reject; the next accepted word clears it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reject_reg <= 1'b0;
      wide_reg   <= 1'b0;
      base_reg   <= '0;
      last_reg   <= '0;
    end
    else if (take)
    begin
      reject_reg <= 1'b0;
      last_reg   <= wword;
      if (wword[3:0] == CODE_FASTLOCK)
      begin
        wide_reg <= wword[AUX_PRE_BIT];
      end
      // R8 base registers tracked until all sent
      if (!wword[MAIN_CODE_BIT])
      begin
        base_reg[0] <= 1'b1;
      end
      case (wword[3:0])
        4'h3:          base_reg[1] <= 1'b1;
        CODE_AUX_N:      base_reg[2] <= 1'b1;
        CODE_REF_ACCESS: base_reg[3] <= 1'b1;
        CODE_FASTLOCK:   base_reg[4] <= 1'b1;
        default:       ;
      endcase
    end
    else if (wr_acc && paddr_i == OFS_TX_WORD)
    begin
      reject_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link sequencer: msb first, data changes while link clock is low
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= ST_IDLE;
      tx_reg    <= '0;
      bit_reg   <= '0;
      cnt_reg   <= '0;
      link.link_clk <= 1'b0;
      link.sdata    <= 1'b0;
      link.latch    <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg  <= ST_SHIFT;
            tx_reg     <= wword;
            bit_reg    <= 5'd23;
            cnt_reg    <= '0;
            link.latch <= 1'b0;
            link.sdata <= wword[23];
          end
        end
        ST_SHIFT:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(LINK_HALF - 1))
          begin
            link.link_clk <= 1'b1;
          end
          else if (cnt_reg == 4'(2 * LINK_HALF - 1))
          begin
            link.link_clk <= 1'b0;
            cnt_reg       <= '0;
            if (bit_reg == 5'd0)
            begin
              state_reg  <= ST_LATCH;
              link.latch <= 1'b1;
            end
            else
            begin
              bit_reg    <= bit_reg - 5'd1;
              link.sdata <= tx_reg[bit_reg - 5'd1];
            end
          end
        end
        ST_LATCH:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(LATCH_HOLD - 1))
          begin
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      link.chip_en <= CE_RESET;
    end
    else
    begin
      link.chip_en <= ce_reg;
    end
  end

endmodule

// *** verification/scfg_link_props.sv ***
/*
  checker of the three-wire link between host and synthesizer ends.
  assumes it watches the interface wires, clocked by clk_i of both ends.
*/
module scfg_link_props
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic link_clk,
  input  wire logic sdata,
  input  wire logic latch,
  input  wire logic chip_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       lc_q;
  logic [5:0] rise_cnt;

  always_ff @(posedge clk_i)
  begin
    if (srst_i) lc_q <= 1'b0;
    else lc_q <= link_clk;
  end

  // counts link rises inside a frame; cleared while latch is high
  always_ff @(posedge clk_i)
  begin
    if (srst_i || latch) rise_cnt <= 6'h00;
    else if (link_clk && !lc_q) rise_cnt <= rise_cnt + 6'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////
  a_latch_clk_low:  assert property (latch |-> !link_clk)
    else $error("link clock high while latched");
  a_data_stable:    assert property (link_clk && lc_q |-> $stable(sdata))
    else $error("serial data moved while link clock high");
  a_clk_high_two:   assert property ($rose(link_clk) |=> link_clk ##1 !link_clk)
    else $error("link clock high phase not two cycles");
  a_clk_low_two:    assert property ($fell(link_clk) && !latch |=> !link_clk ##1 link_clk)
    else $error("link clock low phase not two cycles");
  a_latch_hold:     assert property ($rose(latch) |-> latch [*8])
    else $error("latch high for fewer than eight cycles");
  a_frame_start:    assert property ($fell(latch) |=> !link_clk ##1 link_clk)
    else $error("first link rise not two cycles after frame start");
  a_word_rises:     assert property ($rose(latch) |-> rise_cnt == 6'd24)
    else $error("frame did not carry 24 bits");
  a_frame_len:      assert property ($fell(latch) |-> ##[94:98] $rose(latch))
    else $error("frame length out of range");

  c_frame:   cover property ($rose(latch));
  c_ce_off:  cover property ($fell(chip_en));
  c_ce_on:   cover property ($rose(chip_en));
endmodule

// *** verification/synth_config_access_regs_test.sv ***
/*
  testbench: apb writes to the host end, words cross the link, device
  outputs compared with expected configuration.
  assumes host map TX_WORD/CTRL/STATUS and polling of the busy flag.
*/
module synth_config_access_regs_test;
  import scfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pd, tri_o, wide, auto_power_up, mwr, fault;
  logic [18:0] aux_n;
  logic [11:0] ref_div;
  logic [3:0]  gain, acc;
  logic [4:0]  mult;
  logic [19:0] mfreq, ext, tmo, cnt;
  int          err_count = 0;
  int          cmp_count = 0;
  int          mwr_seen = 0;

  scfg_if link_i ();

  scfg_host scfg_host_i (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link_i.host));

  scfg_device scfg_device_i (.clk_i(clk_i), .srst_i(srst_i), .link(link_i.device),
    .aux_power_down_o(pd), .aux_pump_tristate_o(tri_o), .aux_n_o(aux_n),
    .aux_prescaler_wide_o(wide), .aux_ref_div_o(ref_div), .main_pump_gain_o(gain),
    .main_pump_mult_o(mult), .access_o(acc), .auto_power_up_o(auto_power_up),
    .main_frequency_o(mfreq), .main_freq_wr_o(mwr), .ext_fraction_o(ext),
    .fastlock_timeout_o(tmo), .counter_reset_o(cnt), .access_fault_o(fault));

  scfg_link_props scfg_link_props_i (.clk_i(clk_i), .srst_i(srst_i),
    .link_clk(link_i.link_clk), .sdata(link_i.sdata), .latch(link_i.latch),
    .chip_en(link_i.chip_en));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // main word strobe counted; one pulse per main word
  always @(posedge clk_i)
  begin
    if (mwr === 1'b1)
    begin
      mwr_seen <= mwr_seen + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge at which pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // sends one word and waits until the host is idle again
  task automatic send(input logic [23:0] w);
    logic [31:0] q;
    wr(OFS_TX_WORD, {8'h00, w});
    q = 32'h1;
    while (q[0] !== 1'b0)
    begin
      rd(OFS_STATUS, q);
    end
    repeat (8) @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    logic        e;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp(pd, 1'b1);
    cmp(tri_o, 1'b1);
    cmp({ext, tmo, cnt}, {EXT_FRAC_DFLT, TIMEOUT_DFLT, 20'h00090});
    $display("test reset done");

    wr(OFS_CTRL, 32'h1);
    for (int g = 0; g < 16; g++)
    begin
      send({4'h0, 4'(g), 12'hFFF - 12'(g), 4'h7});
      cmp({gain, mult}, {4'(g), 5'(g + 1)});
      cmp(ref_div, 12'hFFF - 12'(g));
      cmp(acc, 4'h1);
    end
    rd(OFS_TX_WORD, q);
    cmp(q, 32'h001FFF07);
    cmp(fault, 1'b0);
    send({4'h1, 4'h0, 12'h002, 4'h7});
    rd(OFS_STATUS, q);
    cmp(q[1], 1'b1);
    send({4'h1, 4'h0, 12'h003, 4'h7});
    cmp(ref_div, 12'h003);
    $display("test gain and reference done");

    send({20'h12345, 4'hB});
    send({20'hABCDE, 4'hD});
    send({20'h0F0F0, 4'hF});
    cmp({ext, tmo, cnt}, {20'h00000, 20'h00000, 20'h00090});
    send({4'h3, 4'h0, 12'h003, 4'h7});
    cmp({ext, tmo, cnt}, {20'h12345, 20'h00000, 20'h00090});
    send({4'hF, 4'h0, 12'h003, 4'h7});
    cmp({ext, tmo, cnt}, {20'h12345, 20'hABCDE, 20'h0F0F0});
    $display("test optional words done");

    send({1'b0, 19'd1000, 4'h5});
    cmp({pd, tri_o, aux_n}, {2'b00, 19'd1000});
    wr(OFS_CTRL, 32'h0);
    repeat (6) @(posedge clk_i);
    cmp({pd, tri_o}, 2'b11);
    wr(OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk_i);
    cmp(pd, 1'b0);
    send({1'b0, 14'h0, 1'b0, 4'h0, 4'h9});
    send({1'b1, 19'd1000, 4'h5});
    send({20'h55555, 4'h0});
    cmp({pd, mfreq}, {1'b1, 20'h55555});
    send({1'b1, 14'h0, 1'b0, 4'h0, 4'h9});
    cmp(auto_power_up, 1'b1);
    send({20'h2AAAA, 4'h2});
    cmp({pd, mfreq}, {1'b0, 20'h2AAAA});
    $display("test power down done");

    send({1'b0, 14'h0, 1'b1, 4'h0, 4'h9});
    send({1'b0, 19'd47, 4'h5});
    rd(OFS_STATUS, q);
    cmp({wide, q[1], aux_n}, {2'b11, 19'd1000});
    send({1'b0, 19'd240, 4'h5});
    rd(OFS_STATUS, q);
    cmp({q[1], aux_n}, {1'b0, 19'd240});
    send({20'h00001, 4'h3});
    rd(OFS_STATUS, q);
    cmp(q[7:0], 8'hFC);
    $display("test wide prescaler done");

    apb(1'b0, 8'h0C, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1);
    cmp(q, 32'h0);
    cmp(mwr_seen, 2);
    $display("test unmapped done");
    conclude();
  end
endmodule
